// ==== src/local_io_line_function_mux.sv ====
`timescale 1ns/10ps

module local_io_line_function_mux (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic        param_wr,
  input  wire logic        param_rd,
  input  wire logic [15:0] param_addr,
  input  wire logic [15:0] param_wdata,
  output logic      [15:0] param_rdata,
  output logic             param_ack,
  output logic             param_err,
  input  wire logic        power_stage_enabled,
  input  wire logic        local_control_mode,
  input  wire logic        drive_no_fault,
  input  wire logic        drive_ready,
  input  wire logic [3:0]  free_output_value,
  input  wire logic        power_on_apply,
  input  wire logic [3:0]  line_in,
  output logic      [3:0]  line_out,
  output logic      [3:0]  line_oe,
  output logic      [3:0]  io_line_live_state,
  output logic             fault_reset_req,
  output logic             enable_req,
  output logic             halt_req,
  output logic             jog_positive,
  output logic             jog_negative,
  output logic             jog_fast_select,
  output logic             homing_switch,
  output logic             positive_travel_limit,
  output logic             negative_travel_limit
);

  localparam int unsigned N = local_io_pkg::LINE_COUNT;

  logic [N-1:0][15:0] stored_q, stored_d;
  logic [N-1:0][15:0] active_q, active_d;
  logic [15:0]        rdata_q, rdata_d;
  logic               ack_q, ack_d;
  logic               err_q, err_d;
  logic [N-1:0]       hit;
  logic [N-1:0]       code_ok;
  logic [N-1:0]       is_output;

  logic [N-1:0]       out_q, out_d;
  logic [N-1:0]       oe_q, oe_d;
  logic [N-1:0]       live_q, live_d;
  logic [8:0]         func_q, func_d;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_line
      assign hit[g]     = (param_addr == local_io_pkg::line_offset(g));
      assign code_ok[g] = local_io_pkg::code_allowed(param_wdata, g);
      assign is_output[g] = (active_q[g] == local_io_pkg::CODE_FREE_OUT) ||
                            (active_q[g] == local_io_pkg::CODE_NO_FAULT) ||
                            (active_q[g] == local_io_pkg::CODE_READY);
    end : g_line
  endgenerate

  // Selector storage and parameter access
  always_comb begin
    logic hit_any;
    logic accept;
    hit_any  = |hit;
    accept   = 1'b0;
    stored_d = stored_q;
    active_d = active_q;
    rdata_d  = rdata_q;
    for (int i = 0; i < N; i++) begin
      if (param_wr && hit[i] && !power_stage_enabled && code_ok[i]) begin
        stored_d[i] = param_wdata;
        accept      = 1'b1;
      end
      if (param_rd && hit[i]) begin
        rdata_d = stored_q[i];
      end
    end
    // Old function stays in force until the next power-on sequence
    if (power_on_apply) begin
      active_d = stored_q;
    end
    ack_d = param_wr || param_rd;
    err_d = (param_wr && !accept) || (param_rd && !hit_any);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < N; i++) begin
        stored_q[i] <= local_io_pkg::factory_code(i);
        active_q[i] <= local_io_pkg::factory_code(i);
      end
      rdata_q <= 16'h0000;
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
    end else if (ce) begin
      stored_q <= stored_d;
      active_q <= active_d;
      rdata_q  <= rdata_d;
      ack_q    <= ack_d;
      err_q    <= err_d;
    end
  end

  // Line functions: several lines with one input request function are ORed together
  always_comb begin
    out_d  = '0;
    oe_d   = '0;
    live_d = '0;
    func_d = '0;
    for (int i = 0; i < N; i++) begin
      oe_d[i] = is_output[i];
      unique case (active_q[i])
        local_io_pkg::CODE_FREE_IN:     live_d[i] = line_in[i];
        local_io_pkg::CODE_FAULT_RESET: func_d[0] = func_d[0] | (line_in[i] & local_control_mode);
        local_io_pkg::CODE_ENABLE:      func_d[1] = func_d[1] | (line_in[i] & local_control_mode);
        local_io_pkg::CODE_HALT:        func_d[2] = func_d[2] | line_in[i];
        local_io_pkg::CODE_JOG_POS:     func_d[3] = func_d[3] | line_in[i];
        local_io_pkg::CODE_JOG_NEG:     func_d[4] = func_d[4] | line_in[i];
        local_io_pkg::CODE_JOG_FAST:    func_d[5] = func_d[5] | line_in[i];
        local_io_pkg::CODE_HOMING:      func_d[6] = func_d[6] | line_in[i];
        local_io_pkg::CODE_POS_LIMIT:   func_d[7] = func_d[7] | line_in[i];
        local_io_pkg::CODE_NEG_LIMIT:   func_d[8] = func_d[8] | line_in[i];
        local_io_pkg::CODE_FREE_OUT:    out_d[i]  = free_output_value[i];
        local_io_pkg::CODE_NO_FAULT:    out_d[i]  = drive_no_fault;
        local_io_pkg::CODE_READY:       out_d[i]  = drive_ready;
        // Unknown codes can only come from a corrupt store: line stays a dead input
        default: out_d[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      out_q  <= '0;
      oe_q   <= '0;
      live_q <= '0;
      func_q <= '0;
    end else if (ce) begin
      out_q  <= out_d;
      oe_q   <= oe_d;
      live_q <= live_d;
      func_q <= func_d;
    end
  end

  assign param_rdata           = rdata_q;
  assign param_ack             = ack_q;
  assign param_err             = err_q;
  assign line_out              = out_q;
  assign line_oe               = oe_q;
  assign io_line_live_state    = live_q;
  assign fault_reset_req       = func_q[0];
  assign enable_req            = func_q[1];
  assign halt_req              = func_q[2];
  assign jog_positive          = func_q[3];
  assign jog_negative          = func_q[4];
  assign jog_fast_select       = func_q[5];
  assign homing_switch         = func_q[6];
  assign positive_travel_limit = func_q[7];
  assign negative_travel_limit = func_q[8];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_refuse_enabled;
    ce && param_wr && power_stage_enabled |=> $stable(stored_q) && param_err;
  endproperty
  a_refuse_enabled: assert property (p_refuse_enabled) else $error("selector changed while enabled");

  property p_pos_limit_line1;
    ce && param_wr && hit[0] && !power_stage_enabled &&
      param_wdata == local_io_pkg::CODE_POS_LIMIT |=> stored_q[0] == local_io_pkg::CODE_POS_LIMIT;
  endproperty
  a_pos_limit_line1: assert property (p_pos_limit_line1) else $error("line one refused limit");

  property p_pos_limit_other;
    ce && param_wr && (hit[1] || hit[2] || hit[3]) &&
      param_wdata == local_io_pkg::CODE_POS_LIMIT |=> $stable(stored_q) && param_err;
  endproperty
  a_pos_limit_other: assert property (p_pos_limit_other) else $error("positive limit misplaced");

  property p_neg_limit_other;
    ce && param_wr && (hit[0] || hit[2] || hit[3]) &&
      param_wdata == local_io_pkg::CODE_NEG_LIMIT |=> $stable(stored_q) && param_err;
  endproperty
  a_neg_limit_other: assert property (p_neg_limit_other) else $error("negative limit misplaced");

  property p_bad_code;
    ce && param_wr && hit[2] && !code_ok[2] |=> $stable(stored_q[2]) && param_ack && param_err;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("illegal code stored");

  property p_deferred_apply;
    ce && param_wr && hit[3] && code_ok[3] && !power_stage_enabled && !power_on_apply
      |=> stored_q[3] == $past(param_wdata) && active_q[3] == $past(active_q[3]);
  endproperty
  a_deferred_apply: assert property (p_deferred_apply) else $error("selector applied early");

  property p_free_out;
    ce && active_q[2] == local_io_pkg::CODE_FREE_OUT
      |=> line_oe[2] && line_out[2] == $past(free_output_value[2]);
  endproperty
  a_free_out: assert property (p_free_out) else $error("free output wrong");

  property p_ready_out;
    ce && active_q[3] == local_io_pkg::CODE_READY |=> line_out[3] == $past(drive_ready);
  endproperty
  a_ready_out: assert property (p_ready_out) else $error("ready output wrong");

  property p_live_state;
    ce && active_q[2] == local_io_pkg::CODE_FREE_IN
      |=> io_line_live_state[2] == $past(line_in[2]) && !line_oe[2];
  endproperty
  a_live_state: assert property (p_live_state) else $error("live state wrong");

  property p_local_only;
    ce && !local_control_mode |=> !fault_reset_req && !enable_req;
  endproperty
  a_local_only: assert property (p_local_only) else $error("request outside local mode");

  property p_halt_in;
    ce && active_q[1] == local_io_pkg::CODE_HALT && line_in[1] |=> halt_req;
  endproperty
  a_halt_in: assert property (p_halt_in) else $error("halt not seen");

  c_write_then_apply: cover property (ce && param_wr && !param_err ##[1:20] power_on_apply);
  c_refused_write:    cover property (ce && param_wr && power_stage_enabled ##1 param_err);
  c_homing_active:    cover property (ce && homing_switch ##1 positive_travel_limit);

endmodule : local_io_line_function_mux

// ==== src/local_io_pkg.sv ====
package local_io_pkg;

  localparam int unsigned LINE_COUNT = 4;
  localparam int unsigned CODE_W     = 16;

  // Parameter addresses of the four selectors
  localparam logic [15:0] OFS_LINE1 = 16'h0722;
  localparam logic [15:0] OFS_LINE2 = 16'h0724;
  localparam logic [15:0] OFS_LINE3 = 16'h0726;
  localparam logic [15:0] OFS_LINE4 = 16'h0728;

  // Selector codes
  localparam logic [15:0] CODE_FREE_IN     = 16'h0001;
  localparam logic [15:0] CODE_FAULT_RESET = 16'h0002;
  localparam logic [15:0] CODE_ENABLE      = 16'h0003;
  localparam logic [15:0] CODE_HALT        = 16'h0004;
  localparam logic [15:0] CODE_JOG_POS     = 16'h0009;
  localparam logic [15:0] CODE_JOG_NEG     = 16'h000A;
  localparam logic [15:0] CODE_JOG_FAST    = 16'h000B;
  localparam logic [15:0] CODE_HOMING      = 16'h0014;
  localparam logic [15:0] CODE_POS_LIMIT   = 16'h0015;
  localparam logic [15:0] CODE_NEG_LIMIT   = 16'h0016;
  localparam logic [15:0] CODE_FREE_OUT    = 16'h0065;
  localparam logic [15:0] CODE_NO_FAULT    = 16'h0066;
  localparam logic [15:0] CODE_READY       = 16'h0067;

  // Lines that alone may carry the travel limits (zero based)
  localparam int unsigned POS_LIMIT_LINE = 0;
  localparam int unsigned NEG_LIMIT_LINE = 1;

  // Factory assignment
  localparam logic [15:0] FACTORY_LINE1 = CODE_POS_LIMIT;
  localparam logic [15:0] FACTORY_LINE2 = CODE_NEG_LIMIT;
  localparam logic [15:0] FACTORY_LINE3 = CODE_FREE_IN;
  localparam logic [15:0] FACTORY_LINE4 = CODE_HOMING;

  function automatic logic [15:0] line_offset(input int unsigned idx);
    logic [15:0] ofs;
    ofs = OFS_LINE1;
    case (idx)
      1: ofs = OFS_LINE2;
      2: ofs = OFS_LINE3;
      3: ofs = OFS_LINE4;
      default: ofs = OFS_LINE1;
    endcase
    return ofs;
  endfunction : line_offset

  function automatic logic [15:0] factory_code(input int unsigned idx);
    logic [15:0] code;
    code = FACTORY_LINE1;
    case (idx)
      1: code = FACTORY_LINE2;
      2: code = FACTORY_LINE3;
      3: code = FACTORY_LINE4;
      default: code = FACTORY_LINE1;
    endcase
    return code;
  endfunction : factory_code

  function automatic logic code_allowed(input logic [15:0] code, input int unsigned idx);
    logic ok;
    ok = 1'b0;
    case (code)
      CODE_FREE_IN, CODE_FAULT_RESET, CODE_ENABLE, CODE_HALT,
      CODE_JOG_POS, CODE_JOG_NEG, CODE_JOG_FAST, CODE_HOMING,
      CODE_FREE_OUT, CODE_NO_FAULT, CODE_READY: ok = 1'b1;
      CODE_POS_LIMIT: ok = (idx == POS_LIMIT_LINE);
      CODE_NEG_LIMIT: ok = (idx == NEG_LIMIT_LINE);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : code_allowed

endpackage : local_io_pkg

// ==== tb/io_field_partner.sv ====
`timescale 1ns/10ps

// Switches and loads: a line the device drives reads back its own level,
// an undriven line shows the level of its switch, which is always wired
module io_field_partner (
  input  wire logic [3:0] line_out,
  input  wire logic [3:0] line_oe,
  input  wire logic [3:0] sw_level,
  output logic      [3:0] line_in
);
  assign line_in = (line_oe & line_out) | (~line_oe & sw_level);
endmodule : io_field_partner

// ==== tb/tb_local_io_function_mux.sv ====
`timescale 1ns/10ps

module tb_local_io_function_mux;
  logic        clk_sys, arst_n, ce, param_wr, param_rd, param_ack, param_err;
  logic        power_stage_enabled, local_control_mode, drive_no_fault, drive_ready;
  logic        power_on_apply, fault_reset_req, enable_req, halt_req, jog_positive;
  logic        jog_negative, jog_fast_select, homing_switch;
  logic        positive_travel_limit, negative_travel_limit;
  logic [15:0] param_addr, param_wdata, param_rdata;
  logic [3:0]  free_output_value, line_in, line_out, line_oe, io_line_live_state, sw_level;
  logic [15:0] stored[4] = '{16'h0015, 16'h0016, 16'h0001, 16'h0014};
  logic [15:0] active[4] = '{16'h0015, 16'h0016, 16'h0001, 16'h0014};
  // Indices 0..10 fit any line, 11 only line one, 12 only line two, 13 never
  logic [15:0] codes[14] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0009, 16'h000A,
    16'h000B, 16'h0014, 16'h0065, 16'h0066, 16'h0067, 16'h0015, 16'h0016, 16'h0005};
  // Directed code indices per line for the first three rounds, so every code except indices 12 and 13 is applied
  int          dir[12] = '{11, 3, 8, 10, 1, 2, 9, 4, 5, 6, 7, 0};
  logic [31:0] seed = 32'h00007852;
  logic        e;
  int          err_total, compares, cyc;

  local_io_line_function_mux dut (
    .clk_sys               (clk_sys),
    .arst_n                (arst_n),
    .ce                    (ce),
    .param_wr              (param_wr),
    .param_rd              (param_rd),
    .param_addr            (param_addr),
    .param_wdata           (param_wdata),
    .param_rdata           (param_rdata),
    .param_ack             (param_ack),
    .param_err             (param_err),
    .power_stage_enabled   (power_stage_enabled),
    .local_control_mode    (local_control_mode),
    .drive_no_fault        (drive_no_fault),
    .drive_ready           (drive_ready),
    .free_output_value     (free_output_value),
    .power_on_apply        (power_on_apply),
    .line_in               (line_in),
    .line_out              (line_out),
    .line_oe               (line_oe),
    .io_line_live_state    (io_line_live_state),
    .fault_reset_req       (fault_reset_req),
    .enable_req            (enable_req),
    .halt_req              (halt_req),
    .jog_positive          (jog_positive),
    .jog_negative          (jog_negative),
    .jog_fast_select       (jog_fast_select),
    .homing_switch         (homing_switch),
    .positive_travel_limit (positive_travel_limit),
    .negative_travel_limit (negative_travel_limit)
  );
  io_field_partner pm (
    .line_out (line_out),
    .line_oe  (line_oe),
    .sw_level (sw_level),
    .line_in  (line_in)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic bit ok(int k, int i);
    return k < 11 || (k == 11 && i == 0) || (k == 12 && i == 1);
  endfunction : ok

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // Request held from one falling edge over the taking rising edge
  task automatic acc(input bit wr, input logic [15:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk_sys);
    param_wr = wr;
    param_rd = !wr;
    param_addr = a;
    param_wdata = d;
    @(negedge clk_sys);
    param_wr = 1'b0;
    param_rd = 1'b0;
    while (param_ack !== 1'b1 && n < 4) begin
      @(negedge clk_sys);
      n++;
    end
    chk(16'(param_ack), 16'h0001);
    e = param_err;
  endtask : acc

  task automatic wr_chk(input int i, input int k, input bit pse_v);
    power_stage_enabled = pse_v;
    acc(1'b1, 16'h0722 + 16'(2 * i), codes[k]);
    chk(16'(e), 16'(pse_v | !ok(k, i)));
    if (!pse_v && ok(k, i)) stored[i] = codes[k];
    power_stage_enabled = 1'b0;
    acc(1'b0, 16'h0722 + 16'(2 * i), 16'h0000);
    chk(param_rdata, stored[i]);
  endtask : wr_chk

  task automatic vec();
    logic [3:0]  oe, out, live;
    logic [8:0]  f, fs;
    logic [31:0] r;
    r = rnd();
    oe = 4'h0;
    out = 4'h0;
    live = 4'h0;
    f = 9'h000;
    @(negedge clk_sys);
    sw_level = r[3:0];
    free_output_value = r[7:4];
    {drive_no_fault, drive_ready, local_control_mode} = r[10:8];
    for (int i = 0; i < 4; i++) begin
      case (active[i])
        16'h0001: live[i] = sw_level[i];
        16'h0002: f[8] |= sw_level[i] & local_control_mode;
        16'h0003: f[7] |= sw_level[i] & local_control_mode;
        16'h0004: f[6] |= sw_level[i];
        16'h0009: f[5] |= sw_level[i];
        16'h000A: f[4] |= sw_level[i];
        16'h000B: f[3] |= sw_level[i];
        16'h0014: f[2] |= sw_level[i];
        16'h0015: f[1] |= sw_level[i];
        16'h0016: f[0] |= sw_level[i];
        16'h0065: {oe[i], out[i]} = {1'b1, free_output_value[i]};
        16'h0066: {oe[i], out[i]} = {1'b1, drive_no_fault};
        16'h0067: {oe[i], out[i]} = {1'b1, drive_ready};
      endcase
    end
    @(negedge clk_sys);
    chk(16'({line_oe, line_out & line_oe}), 16'({oe, out}));
    chk(16'(io_line_live_state), 16'(live));
    fs = {fault_reset_req, enable_req, halt_req, jog_positive, jog_negative,
      jog_fast_select, homing_switch, positive_travel_limit, negative_travel_limit};
    chk(16'(fs), 16'(f));
  endtask : vec

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    {arst_n, param_wr, param_rd, power_stage_enabled, power_on_apply} = 5'h00;
    {local_control_mode, drive_no_fault, drive_ready, ce} = 4'h1;
    {param_addr, param_wdata, free_output_value, sw_level} = 40'h0;
    repeat (20) @(negedge clk_sys);
    arst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 16'h0722 + 16'(2 * i), 16'h0000);
      chk(param_rdata, stored[i]);
    end
    acc(1'b0, 16'h0730, 16'h0000);
    chk(16'(e), 16'h0001);
    repeat (4) vec();
    // Frozen enable: a write is neither taken nor answered
    @(negedge clk_sys);
    {ce, param_wr, param_addr, param_wdata} = {1'b0, 1'b1, 16'h0726, 16'h0065};
    @(negedge clk_sys);
    param_wr = 1'b0;
    chk(16'(param_ack), 16'h0000);
    ce = 1'b1;
    wr_chk(2, 13, 1'b0);
    $display("test factory done");
    for (int i = 0; i < 4; i++)
      for (int k = 0; k < 14; k++)
        wr_chk(i, k, 1'b0);
    for (int i = 0; i < 4; i++)
      wr_chk(i, 0, 1'b1);
    $display("test select done");
    // First three rounds place every code except 12 and 13 on some line, then random ones
    for (int n = 0; n < 11; n++) begin
      for (int i = 0; i < 4; i++)
        wr_chk(i, n < 3 ? dir[4 * n + i] : int'(rnd() % 14), 1'b0);
      // Pending selections must not touch the lines yet
      repeat (3) vec();
      @(negedge clk_sys);
      power_on_apply = 1'b1;
      @(negedge clk_sys);
      power_on_apply = 1'b0;
      active = stored;
      repeat (2) @(negedge clk_sys);
      repeat (8) vec();
    end
    $display("test random done");
    wrap_up();
  end
endmodule : tb_local_io_function_mux
